//--- src/spd_regs.svh
//==========================================================================
// Contract
// - programming enable needs 0xAC then 0x53, accepted only while reset pin low
// - 0xAC with byte two 100x_xxxx erases all flash and eeprom to 0xFF
// - flash byte access: 10-bit word address, H bit picks byte, 0x20 reads, 0x40 writes
// - 0xA0 0x00 returns eeprom byte at low seven bits of byte three
// - 0xC0 0x00 writes byte four into eeprom at low seven bits of byte three
// - 0x58 returns lock1 bit7, lock2 bit6, download fuse bit5, startup fuse bit0
// - 0xAC with 1111_1xx1 programs lock2 if bit2 zero, lock1 if bit1 zero
// - 0xAC with 1011_111x writes startup fuse from bit0, zero programs it
// - startup fuse change acts only after the next power cycle; the code also applies it on an apb write of the reload bit
// - 0x30 returns signature byte chosen by byte three, hidden in lock mode 3
// - serial input sampled on the rising serial clock edge
// - serial output shifted on the falling serial clock edge
// - in sync, the 0x53 byte echoes back while byte three arrives
//==========================================================================
// constants of the serial programming decoder: offsets, opcodes, fields, resets
// assumes nothing of its surroundings; holds only macro definitions
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ==========================================
// apb register offsets and fields
`define SPD_CTRL_OFS 12'h000
`define SPD_STAT_OFS 12'h004
`define SPD_CTRL_RELOAD_BIT 0
`define SPD_STAT_PROG_EN_BIT 0
`define SPD_STAT_ERASE_BIT 1
`define SPD_STAT_LOCK1_BIT 2
`define SPD_STAT_LOCK2_BIT 3
`define SPD_STAT_FUSE_NV_BIT 4
`define SPD_STAT_FUSE_EFF_BIT 5
`define SPD_STAT_MODE_BIT 6

// ==========================================
// instruction byte patterns
`define SPD_MASK_ALL 8'hFF
`define SPD_OP_PROG 8'hAC
`define SPD_PE_KEY 8'h53
`define SPD_CE_MASK 8'hE0
`define SPD_CE_VAL 8'h80
`define SPD_FL_MASK 8'hF7
`define SPD_FL_RD 8'h20
`define SPD_FL_WR 8'h40
`define SPD_EE_RD 8'hA0
`define SPD_EE_WR 8'hC0
`define SPD_ZERO_BYTE 8'h00
`define SPD_LF_RD 8'h58
`define SPD_LK_MASK 8'hF9
`define SPD_LK_VAL 8'hF9
`define SPD_FS_MASK 8'hFE
`define SPD_FS_VAL 8'hBE
`define SPD_SIG_RD 8'h30
`define SPD_H_BIT 3
`define SPD_LK1_WR_BIT 1
`define SPD_LK2_WR_BIT 2
`define SPD_FS_WR_BIT 0

// ==========================================
// lock and fuse read byte positions
`define SPD_LF_L1_BIT 7
`define SPD_LF_L2_BIT 6
`define SPD_LF_SDE_BIT 5
`define SPD_LF_FUSE_BIT 0

// ==========================================
// reset values (1 = unprogrammed)
`define SPD_LOCK_RST 1'b1
`define SPD_FUSE_RST 1'b1
`define SPD_SDE_VAL 1'b0
`define SPD_ERASED 8'hFF
`define SPD_NOMATCH 8'h00
`define SPD_SIG_HIDDEN 8'h00

`endif

//--- src/spd_pkg.sv
// types shared by the serial programming decoder
// assumes nothing of its surroundings
package spd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_RESP,
      ST_EXEC,
      ST_ERASE
   } spd_state_t;
endpackage

//--- src/spd_mem.sv
// byte-wide memory with registered read data
// assumes one clock, write and read on the same address port
`timescale 1ns/1ps
module spd_mem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem_ff [2**AW];
   logic [DW-1:0] rdata_ff;

   // array itself is not reset: content survives like nonvolatile cells
   always_ff @(posedge clk) begin
      if (we) begin
         mem_ff[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem_ff[addr];
      end
   end

   assign rdata = rdata_ff;
endmodule

//--- src/spd_link.sv
// serial link shifter running on the programmer's serial clock
// assumes arst_n holds it in reset outside programming mode
`timescale 1ns/1ps
module spd_link (
   input wire logic sck,
   input wire logic arst_n,
   input wire logic mosi,
   input wire logic [7:0] resp_byte,
   output logic miso,
   output logic [7:0] rx_byte,
   output logic [1:0] rx_idx,
   output logic rx_tog
);
   logic [4:0] cnt_ff;
   logic [6:0] sh_ff;
   logic [7:0] rx_ff;
   logic [1:0] idx_ff;
   logic tog_ff;
   logic [7:0] tx_ff;

   // ==========================================
   // receive side
   // rising edge sampling
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= '0;
         sh_ff <= '0;
         rx_ff <= '0;
         idx_ff <= '0;
         tog_ff <= 1'b0;
      end else begin
         sh_ff <= {sh_ff[5:0], mosi};
         cnt_ff <= cnt_ff + 5'd1;
         if (cnt_ff[2:0] == 3'd7) begin
            rx_ff <= {sh_ff, mosi};
            idx_ff <= cnt_ff[4:3];
            tog_ff <= ~tog_ff;
         end
      end
   end

   // ==========================================
   // transmit side
   // falling edge shifting
   always_ff @(negedge sck or negedge arst_n) begin
      if (!arst_n) begin
         tx_ff <= '0;
      end else if (cnt_ff[2:0] == 3'd0) begin
         tx_ff <= (cnt_ff[4:3] == 2'd3) ? resp_byte : rx_ff;
      end else begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   assign miso = tx_ff[7];
   assign rx_byte = rx_ff;
   assign rx_idx = idx_ff;
   assign rx_tog = tog_ff;
endmodule

//--- src/spd_top.sv
// serial programming instruction decoder with apb status and control
// assumes pclk at 40 MHz, sck from the programmer unrelated in phase
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_top
   import spd_pkg::*;
#(
   // arbitrary signature values, not those of any part
   parameter logic [7:0] SIG_B0 = 8'h5A,
   parameter logic [7:0] SIG_B1 = 8'hA5,
   parameter logic [7:0] SIG_B2 = 8'h3C,
   parameter logic [7:0] SIG_B3 = 8'hFF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sck,
   input wire logic rst_pin_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   output logic short_startup_fuse
);
   // ==========================================
   // declarations
   logic rpin_s1_ff;
   logic rpin_s2_ff;
   logic prog_mode_ff;
   logic tog_s1_ff;
   logic tog_s2_ff;
   logic tog_s3_ff;
   logic byte_ev;
   logic [7:0] rx_byte;
   logic [1:0] rx_idx;
   logic rx_tog;
   logic [7:0] instr_ff [4];
   spd_state_t st_ff;
   spd_state_t nxt_st;
   logic prog_en_ff;
   logic lock1_ff;
   logic lock2_ff;
   logic fuse_nv_ff;
   logic fuse_eff_ff;
   logic boot_ff;
   logic [10:0] er_cnt_ff;
   logic [7:0] resp_ff;
   logic [7:0] nxt_resp;
   logic [7:0] lf_byte;
   logic fl_we;
   logic [10:0] fl_addr;
   logic [7:0] fl_wdata;
   logic [7:0] fl_rdata;
   logic ee_we;
   logic [6:0] ee_addr;
   logic [7:0] ee_wdata;
   logic [7:0] ee_rdata;
   logic is_pe;
   logic is_ce;
   logic is_flr;
   logic is_flw;
   logic is_eer;
   logic is_eew;
   logic is_lfr;
   logic is_lkw;
   logic is_fsw;
   logic is_sig;
   logic exec_ok;
   logic apb_acc;
   logic apb_done;
   logic reload;
   logic mapped;
   logic [31:0] rd_val;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   function automatic logic op_is(input logic [7:0] b, input logic [7:0] mask,
                                  input logic [7:0] val);
      return (b & mask) == val;
   endfunction

   function automatic logic [7:0] sig_byte(input logic [1:0] sel);
      case (sel)
         2'd0: return SIG_B0;
         2'd1: return SIG_B1;
         2'd2: return SIG_B2;
         default: return SIG_B3;
      endcase
   endfunction

   // ==========================================
   // reset pin and link crossing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rpin_s1_ff <= 1'b1;
         rpin_s2_ff <= 1'b1;
         prog_mode_ff <= 1'b0;
      end else begin
         rpin_s1_ff <= rst_pin_n;
         rpin_s2_ff <= rpin_s1_ff;
         prog_mode_ff <= ~rpin_s2_ff;
      end
   end

   // link held in reset while the core runs, so stale toggles are dropped here too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_s1_ff <= 1'b0;
         tog_s2_ff <= 1'b0;
         tog_s3_ff <= 1'b0;
      end else if (!prog_mode_ff) begin
         tog_s1_ff <= 1'b0;
         tog_s2_ff <= 1'b0;
         tog_s3_ff <= 1'b0;
      end else begin
         tog_s1_ff <= rx_tog;
         tog_s2_ff <= tog_s1_ff;
         tog_s3_ff <= tog_s2_ff;
      end
   end

   assign byte_ev = tog_s2_ff ^ tog_s3_ff;

   // slow clock keeps byte stable
   // rx_byte and rx_idx are read only after the toggle crossed; they stay put
   // for eight more serial clocks, far longer than the three-cycle crossing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            instr_ff[i] <= '0;
         end
      end else if (byte_ev && st_ff != ST_ERASE) begin
         instr_ff[rx_idx] <= rx_byte;
      end
   end

   spd_link u_link (
      .sck(sck),
      .arst_n(prog_mode_ff),
      .mosi(mosi),
      .resp_byte(resp_ff),
      .miso(miso),
      .rx_byte(rx_byte),
      .rx_idx(rx_idx),
      .rx_tog(rx_tog)
   );

   // ==========================================
   // instruction decode
   // masked compares ignore don't-care bits
   always_comb begin
      is_pe = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_OP_PROG)
              && op_is(instr_ff[1], `SPD_MASK_ALL, `SPD_PE_KEY);
      is_ce = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_OP_PROG)
              && op_is(instr_ff[1], `SPD_CE_MASK, `SPD_CE_VAL);
      is_flr = op_is(instr_ff[0], `SPD_FL_MASK, `SPD_FL_RD);
      is_flw = op_is(instr_ff[0], `SPD_FL_MASK, `SPD_FL_WR);
      is_eer = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_EE_RD)
               && op_is(instr_ff[1], `SPD_MASK_ALL, `SPD_ZERO_BYTE);
      is_eew = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_EE_WR)
               && op_is(instr_ff[1], `SPD_MASK_ALL, `SPD_ZERO_BYTE);
      is_lfr = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_LF_RD);
      is_lkw = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_OP_PROG)
               && op_is(instr_ff[1], `SPD_LK_MASK, `SPD_LK_VAL);
      is_fsw = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_OP_PROG)
               && op_is(instr_ff[1], `SPD_FS_MASK, `SPD_FS_VAL);
      is_sig = op_is(instr_ff[0], `SPD_MASK_ALL, `SPD_SIG_RD);
   end

   assign exec_ok = (st_ff == ST_EXEC) && prog_en_ff;

   // ==========================================
   // sequencer
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (byte_ev && rx_idx == 2'd2) begin
               nxt_st = ST_ADDR;
            end else if (byte_ev && rx_idx == 2'd3) begin
               nxt_st = ST_EXEC;
            end
         end
         ST_ADDR: nxt_st = ST_RESP;
         ST_RESP: nxt_st = ST_IDLE;
         ST_EXEC: begin
            nxt_st = (prog_en_ff && is_ce) ? ST_ERASE : ST_IDLE;
         end
         ST_ERASE: begin
            if (er_cnt_ff == 11'h7FF) begin
               nxt_st = ST_IDLE;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_IDLE;
      end else if (!prog_mode_ff && st_ff != ST_ERASE) begin
         st_ff <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         er_cnt_ff <= '0;
      end else if (st_ff == ST_ERASE) begin
         er_cnt_ff <= er_cnt_ff + 11'd1;
      end else begin
         er_cnt_ff <= '0;
      end
   end

   // ==========================================
   // memory ports
   always_comb begin
      fl_addr = {instr_ff[1][1:0], instr_ff[2], instr_ff[0][`SPD_H_BIT]};
      fl_wdata = instr_ff[3];
      fl_we = exec_ok && is_flw;
      ee_addr = instr_ff[2][6:0];
      ee_wdata = instr_ff[3];
      ee_we = exec_ok && is_eew;
      if (st_ff == ST_ERASE) begin
         fl_addr = er_cnt_ff;
         fl_wdata = `SPD_ERASED;
         fl_we = 1'b1;
         ee_addr = er_cnt_ff[6:0];
         ee_wdata = `SPD_ERASED;
         ee_we = 1'b1;
      end
   end

   spd_mem #(.AW(11), .DW(8)) u_flash (
      .clk(pclk),
      .rst_n(presetn),
      .we(fl_we),
      .addr(fl_addr),
      .wdata(fl_wdata),
      .rdata(fl_rdata)
   );

   spd_mem #(.AW(7), .DW(8)) u_eeprom (
      .clk(pclk),
      .rst_n(presetn),
      .we(ee_we),
      .addr(ee_addr),
      .wdata(ee_wdata),
      .rdata(ee_rdata)
   );

   // ==========================================
   // answer byte
   always_comb begin
      lf_byte = '0;
      lf_byte[`SPD_LF_L1_BIT] = lock1_ff;
      lf_byte[`SPD_LF_L2_BIT] = lock2_ff;
      lf_byte[`SPD_LF_SDE_BIT] = `SPD_SDE_VAL;
      lf_byte[`SPD_LF_FUSE_BIT] = fuse_nv_ff;
      nxt_resp = `SPD_NOMATCH;
      if (!prog_en_ff) begin
         nxt_resp = `SPD_NOMATCH;
      end else if (is_flr) begin
         nxt_resp = fl_rdata;
      end else if (is_eer) begin
         nxt_resp = ee_rdata;
      end else if (is_lfr) begin
         nxt_resp = lf_byte;
      end else if (is_sig) begin
         nxt_resp = (!lock1_ff && !lock2_ff) ? `SPD_SIG_HIDDEN : sig_byte(instr_ff[2][1:0]);
      end
   end

   // must settle before byte three's last falling serial edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_ff <= `SPD_NOMATCH;
      end else if (st_ff == ST_RESP) begin
         resp_ff <= nxt_resp;
      end
   end

   // ==========================================
   // enable, lock and fuse state
   // enable only in programming mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_en_ff <= 1'b0;
      end else if (!prog_mode_ff) begin
         prog_en_ff <= 1'b0;
      end else if (st_ff == ST_EXEC && is_pe) begin
         prog_en_ff <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock1_ff <= `SPD_LOCK_RST;
         lock2_ff <= `SPD_LOCK_RST;
      end else if (exec_ok && is_lkw) begin
         lock1_ff <= lock1_ff & instr_ff[1][`SPD_LK1_WR_BIT];
         lock2_ff <= lock2_ff & instr_ff[1][`SPD_LK2_WR_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_nv_ff <= `SPD_FUSE_RST;
      end else if (exec_ok && is_fsw) begin
         fuse_nv_ff <= instr_ff[1][`SPD_FS_WR_BIT];
      end
   end

   // fuse applies at power-up
   // boot_ff catches the stored value right after reset release; software may
   // mimic a power cycle through the reload bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_ff <= 1'b1;
         fuse_eff_ff <= `SPD_FUSE_RST;
      end else begin
         boot_ff <= 1'b0;
         if (boot_ff || reload) begin
            fuse_eff_ff <= fuse_nv_ff;
         end
      end
   end

   // ==========================================
   // apb slave, one wait state
   assign apb_acc = psel && penable;
   assign apb_done = apb_acc && pready_ff;
   assign reload = apb_done && pwrite && paddr == `SPD_CTRL_OFS
                   && pwdata[`SPD_CTRL_RELOAD_BIT];

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      if (paddr == `SPD_CTRL_OFS) begin
         rd_val = 32'h0000_0000;
      end else if (paddr == `SPD_STAT_OFS) begin
         rd_val[`SPD_STAT_PROG_EN_BIT] = prog_en_ff;
         rd_val[`SPD_STAT_ERASE_BIT] = (st_ff == ST_ERASE);
         rd_val[`SPD_STAT_LOCK1_BIT] = lock1_ff;
         rd_val[`SPD_STAT_LOCK2_BIT] = lock2_ff;
         rd_val[`SPD_STAT_FUSE_NV_BIT] = fuse_nv_ff;
         rd_val[`SPD_STAT_FUSE_EFF_BIT] = fuse_eff_ff;
         rd_val[`SPD_STAT_MODE_BIT] = prog_mode_ff;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_acc && !pready_ff;
         if (apb_acc && !pready_ff) begin
            pslverr_ff <= !mapped;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
         end else begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;
   assign miso_oe = prog_mode_ff;
   assign short_startup_fuse = fuse_eff_ff;

   // ==========================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   prog_en_gate_a: assert property (
      rpin_s2_ff |-> ##2 !prog_en_ff)
      else $error("programming stayed enabled with reset pin high");

   erase_sweep_a: assert property (
      (exec_ok && is_ce) |=> (fl_we && ee_we && fl_wdata == 8'hFF && er_cnt_ff == 11'd0))
      else $error("chip erase did not start a full sweep");

   flash_addr_a: assert property (
      (exec_ok && is_flw) |-> (fl_we
         && fl_addr == {instr_ff[1][1:0], instr_ff[2], instr_ff[0][3]}))
      else $error("flash write went to the wrong byte");

   flash_read_a: assert property (
      (st_ff == ST_ADDR && prog_en_ff && is_flr) |=> ##1 (resp_ff == $past(fl_rdata)))
      else $error("flash read answer differs from memory");

   ee_read_a: assert property (
      (st_ff == ST_RESP && prog_en_ff && is_eer) |=> (resp_ff == $past(ee_rdata)))
      else $error("eeprom read answer differs from memory");

   ee_write_a: assert property (
      (exec_ok && is_eew) |-> (ee_we && ee_addr == instr_ff[2][6:0]
         && ee_wdata == instr_ff[3]))
      else $error("eeprom write address or data wrong");

   lock_read_a: assert property (
      (st_ff == ST_RESP && prog_en_ff && is_lfr) |=> (resp_ff[7] == lock1_ff
         && resp_ff[6] == lock2_ff && resp_ff[5] == 1'b0 && resp_ff[0] == fuse_nv_ff))
      else $error("lock and fuse byte layout wrong");

   lock_sticky_a: assert property (
      !$rose(lock1_ff) && !$rose(lock2_ff))
      else $error("a programmed lock bit was released");

   fuse_write_a: assert property (
      (exec_ok && is_fsw) |=> (fuse_nv_ff == $past(instr_ff[1][0])))
      else $error("startup fuse not written from bit zero");

   fuse_defer_a: assert property (
      (!boot_ff && !reload) |=> $stable(fuse_eff_ff))
      else $error("startup fuse acted before a power cycle");

   sig_hidden_a: assert property (
      (st_ff == ST_RESP && prog_en_ff && is_sig && !lock1_ff && !lock2_ff)
         |=> resp_ff == 8'h00)
      else $error("signature readable in lock mode 3");

   no_match_a: assert property (
      (st_ff == ST_EXEC && !(prog_en_ff && (is_ce || is_flw || is_eew || is_lkw || is_fsw)))
         |-> (!fl_we && !ee_we) ##1 ($stable(lock1_ff) && $stable(fuse_nv_ff)))
      else $error("unmatched instruction changed stored state");
endmodule

//--- verif/spd_prog_model.sv
// programmer model: shifts four-byte instructions over sck/mosi, captures miso
// assumes the device is already in programming mode when xfer is called
`timescale 1ns/1ps
module spd_prog_model #(
   parameter real HALF = 60.0
) (
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   // ==========================================
   // link idle
   // sck stands low outside frames
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   // ==========================================
   // instruction transfer
   task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
      for (int i = 31; i >= 0; i--) begin
         mosi = cmd[i];
         #(HALF);
         sck = 1'b1;
         rsp[i] = miso;
         #(HALF);
         // gap lets the core load the next answer before the byte's last fall
         if (i % 8 == 0)
            #250;
         sck = 1'b0;
      end
      // released line shows no stale value
      mosi = ~cmd[0];
      #250;
   endtask
endmodule

//--- verif/testbench.sv
// self-checking bench: apb status checks and serial programming scenarios
// assumes spd_top with default signature parameters, spd_prog_model as programmer
`timescale 1ns/1ps
module testbench;
   import spd_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, sck, mosi, miso, miso_oe, fuse;
   logic rst_pin_n = 1'b1;
   int err_total = 0;
   int checks_done = 0;
   // lock and fuse bits as the scenarios leave them, 1 = unprogrammed
   logic [1:0] lk_seen = 2'b11;
   logic [1:0] fz_seen = 2'b11;
   always #12.5 pclk = ~pclk;
   spd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck(sck), .rst_pin_n(rst_pin_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .short_startup_fuse(fuse));
   spd_prog_model i_prog (.sck(sck), .mosi(mosi), .miso(miso));
   // ==========================================
   // helpers
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic er);
      int n;
      n = 0;
      // serial transfers return off the pclk grid; start the setup cycle on an edge
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20) begin
         err_total++;
         complete_run();
      end
   endtask
   task automatic stat(input logic [31:0] e);
      logic [31:0] q;
      logic er;
      apb(1'b0, 12'h004, 32'h0000_0000, q, er);
      chk("stat", e, q);
   endtask
   task automatic rd(input logic [31:0] c, input logic [7:0] e);
      logic [31:0] r;
      i_prog.xfer(c, r);
      chk("answer", {24'h00_0000, e}, {24'h00_0000, r[7:0]});
   endtask
   // ==========================================
   // scenarios
   task automatic enter;
      logic [31:0] r;
      int n;
      rst_pin_n <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (miso_oe !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         complete_run();
      end
      stat(32'h0000_0040 | (stat_locks()));
      i_prog.xfer(32'hAC53_0000, r);
      chk("echo", 32'h0000_0053, {24'h00_0000, r[15:8]});
   endtask
   function automatic logic [31:0] stat_locks();
      return {28'h000_0000, 4'h0} | (lk_seen << 2) | (fz_seen << 4);
   endfunction
   task automatic t_regs;
      logic [31:0] q;
      logic er;
      stat(32'h0000_003C);
      apb(1'b1, 12'h008, 32'hFFFF_FFFF, q, er);
      chk("unmapped err", 32'h0000_0001, {31'h0000_0000, er});
      chk("unmapped data", 32'h0000_0000, q);
   endtask
   task automatic t_mem;
      logic [31:0] r;
      stat(32'h0000_007D);
      i_prog.xfer(32'hC000_FF96, r);
      i_prog.xfer(32'hC000_003C, r);
      rd(32'hA000_7F00, 8'h96);
      rd(32'hA000_0000, 8'h3C);
      i_prog.xfer(32'h4803_FFC3, r);
      i_prog.xfer(32'h4003_FF1E, r);
      rd(32'h2803_FF00, 8'hC3);
      rd(32'h2003_FF00, 8'h1E);
      i_prog.xfer(32'hFF00_7F00, r);
      rd(32'hA000_7F00, 8'h96);
   endtask
   task automatic t_sig;
      logic [7:0] sig [4];
      sig = '{8'h5A, 8'hA5, 8'h3C, 8'hFF};
      for (int b = 0; b < 4; b++)
         rd(32'h30FF_FC00 | (b << 8), sig[b]);
   endtask
   task automatic t_fuse;
      logic [31:0] r;
      logic er;
      rd(32'h5800_0000, 8'hC1);
      i_prog.xfer(32'hACBE_0000, r);
      rd(32'h58FF_FF00, 8'hC0);
      chk("fuse pin", 32'h0000_0001, {31'h0000_0000, fuse});
      stat(32'h0000_006D);
      apb(1'b1, 12'h000, 32'h0000_0001, r, er);
      chk("fuse pin", 32'h0000_0000, {31'h0000_0000, fuse});
      stat(32'h0000_004D);
      fz_seen = 2'b00;
   endtask
   task automatic t_lock;
      logic [31:0] r;
      i_prog.xfer(32'hACFD_0000, r);
      rd(32'h5800_0000, 8'h40);
      rd(32'h3000_0000, 8'h5A);
      i_prog.xfer(32'hACF9_0000, r);
      rd(32'h5800_0000, 8'h00);
      stat(32'h0000_0041);
      rd(32'h3000_0100, 8'h00);
      lk_seen = 2'b00;
   endtask
   task automatic t_erase;
      logic [31:0] r;
      i_prog.xfer(32'hAC9F_0000, r);
      repeat (2100) @(posedge pclk);
      rst_pin_n <= 1'b1;
      repeat (6) @(posedge pclk);
      enter();
      rd(32'hA000_7F00, 8'hFF);
      rd(32'h2803_FF00, 8'hFF);
      rd(32'h2003_FF00, 8'hFF);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      enter();
      t_mem();
      t_sig();
      t_fuse();
      t_lock();
      t_erase();
      complete_run();
   end
endmodule
